// ==== sfcfe_pkg.sv ====
// Shared constants for the serial flash command front end
package sfcfe_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_WR_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WR_LOCK = 8'h04;
  localparam logic [7:0] OP_ID = 8'h9f;
  localparam logic [7:0] OP_ID_SHORT = 8'h9e;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
  localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;
  // ==========================================================
  // Identification bytes
  localparam logic [7:0] ID_MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] ID_TYPE = 8'h61; // Arbitrary value
  localparam logic [7:0] ID_CAP = 8'h17; // Arbitrary value
  localparam logic [7:0] ID_SIG = 8'h3c; // Arbitrary value
  localparam logic [7:0] ID_LEN = 8'h10;
  localparam logic [7:0] ID_CUST = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ==========================================================
  // Frame byte positions, opcode is byte 0
  localparam logic [8:0] N_OP = 9'h001;
  localparam logic [8:0] N_WRSR_END = 9'h002;
  localparam logic [8:0] N_ADDR_END = 9'h004;
  localparam logic [8:0] N_FAST_DATA = 9'h005;
  localparam logic [8:0] N_PAGE_END = 9'h104;
  localparam logic [8:0] N_ID_END = 9'h015;
  localparam logic [8:0] N_ID_SHORT_END = 9'h004;
  localparam logic [8:0] N_NONE = 9'h000;
  localparam logic [8:0] N_MAX = 9'h1ff;
  // ==========================================================
  // Status byte and address map
  localparam int ST_BUSY = 0;
  localparam int ST_WUL = 1;
  localparam logic [7:0] ST_NV_MASK = 8'h9c;
  localparam logic [7:0] ST_RESET = 8'h00;
  localparam logic [23:0] ADDR_MASK = 24'h3fffff;
  localparam int SECTOR_MSB = 21;
  localparam int SECTOR_LSB = 16;
  // ==========================================================
  // Timing
  localparam int CORE_PERIOD_NS = 10;
  localparam int T_WRSR_NS = 5000;
  localparam int T_PAGE_NS = 8000;
  localparam int T_SECT_NS = 30000;
  localparam int T_BULK_NS = 40000;
  localparam int CYC_WRSR = T_WRSR_NS / CORE_PERIOD_NS;
  localparam int CYC_PAGE = T_PAGE_NS / CORE_PERIOD_NS;
  localparam int CYC_SECT = T_SECT_NS / CORE_PERIOD_NS;
  localparam int CYC_BULK = T_BULK_NS / CORE_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 4;
  localparam int T_DESEL_NS = 100;
  localparam int DESEL_CYC = (T_DESEL_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
endpackage

// ==== sfcfe_link_if.sv ====
// Serial link between host and flash front end
`timescale 1ns/1ns
interface sfcfe_link_if;
  logic sclk;
  logic sel_n;
  logic serial_data_in;
  logic sdo_drv;
  logic sdo_oe_n;
  logic serial_data_out;
  // Pull-up holds the shared data-out line high when undriven
  assign serial_data_out = sdo_oe_n ? 1'b1 : sdo_drv;
  modport device (
    input sclk,
    input sel_n,
    input serial_data_in,
    output sdo_drv,
    output sdo_oe_n
  );
  modport host (
    output sclk,
    output sel_n,
    output serial_data_in,
    input serial_data_out
  );
endinterface

// ==== sfcfe_device.sv ====
// Flash command front end, device end of the serial link
// Functional notes
// - All bytes travel most significant bit first
// - Sample from first rising edge after select
// - Frame opens with one opcode byte
// - Read-type output may end at any bit
// - Write-type frames need whole-byte deselect
// - Internal cycle ignores array access attempts
// - 03h and 0Bh address, dummy, stream
// - 02h, D8h, C7h byte layouts
// - B9h power-down, ABh release and signature
// - 06h sets write-unlock latch
// - 04h clears write-unlock latch
// - Writes refused while latch is clear
// - Latch clears at reset and completion
// - 9Fh gives 20 id bytes, 9Eh three
// - Length byte 10h, then zero customer bytes
// - Id bits shift out on falling edge
// - Id command ignored during program or erase
// - Host never sends id in power-down
// - Deselect ends id output, back to standby
// - Status readable anytime, repeats while clocked; the code refuses 05h in power-down
// - Host polls busy before new commands
// - Sixty-four sectors of 64 KiB each
// - Busy flag high during internal cycles
`timescale 1ns/1ns
module sfcfe_device (
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Serial link
  sfcfe_link_if.device link,
  // Execution requests to the array engine
  output logic o_exec_valid,
  output logic [7:0] o_exec_op,
  output logic [23:0] o_exec_addr,
  output logic [5:0] o_exec_sector,
  output logic [7:0] o_exec_data,
  // Device state
  output logic o_busy,
  output logic o_write_unlock_latch,
  output logic o_power_down,
  output logic [7:0] o_status
);
  typedef enum logic [2:0] {PH_OP = 3'b001, PH_RUN = 3'b010, PH_IGN = 3'b100} sfcfe_ph_e;
  typedef enum logic [1:0] {CS_IDLE = 2'b01, CS_BUSY = 2'b10} sfcfe_cs_e;

  // ==========================================================
  // Decode helpers
  function automatic logic allowed(input logic [7:0] op, input logic pd, input logic busy);
    logic ok;
    ok = 1'b0;
    case (op)
      sfcfe_pkg::OP_WR_UNLOCK, sfcfe_pkg::OP_WR_LOCK, sfcfe_pkg::OP_STATUS_RD,
      sfcfe_pkg::OP_STATUS_WR, sfcfe_pkg::OP_PAGE_PROG, sfcfe_pkg::OP_SECTOR_ERASE,
      sfcfe_pkg::OP_BULK_ERASE, sfcfe_pkg::OP_POWER_DOWN, sfcfe_pkg::OP_RELEASE: ok = 1'b1;
      sfcfe_pkg::OP_READ, sfcfe_pkg::OP_FAST_READ, sfcfe_pkg::OP_ID,
      sfcfe_pkg::OP_ID_SHORT: ok = ~busy;
      default: ok = 1'b0;
    endcase
    if (pd) begin
      ok = (op == sfcfe_pkg::OP_RELEASE);
    end
    return ok;
  endfunction

  // Deselect after n whole bytes executes the command
  function automatic logic arm_ok(input logic [7:0] op, input logic [8:0] n);
    case (op)
      sfcfe_pkg::OP_WR_UNLOCK, sfcfe_pkg::OP_WR_LOCK, sfcfe_pkg::OP_BULK_ERASE,
      sfcfe_pkg::OP_POWER_DOWN: return n == sfcfe_pkg::N_OP;
      sfcfe_pkg::OP_SECTOR_ERASE: return n == sfcfe_pkg::N_ADDR_END;
      sfcfe_pkg::OP_STATUS_WR: return n == sfcfe_pkg::N_WRSR_END;
      sfcfe_pkg::OP_PAGE_PROG: return n > sfcfe_pkg::N_ADDR_END && n <= sfcfe_pkg::N_PAGE_END;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [8:0] data_start(input logic [7:0] op);
    case (op)
      sfcfe_pkg::OP_STATUS_RD, sfcfe_pkg::OP_ID, sfcfe_pkg::OP_ID_SHORT: return sfcfe_pkg::N_OP;
      sfcfe_pkg::OP_READ, sfcfe_pkg::OP_RELEASE: return sfcfe_pkg::N_ADDR_END;
      sfcfe_pkg::OP_FAST_READ: return sfcfe_pkg::N_FAST_DATA;
      default: return sfcfe_pkg::N_MAX;
    endcase
  endfunction

  function automatic logic [7:0] tx_byte(input logic [7:0] op, input logic [8:0] n,
                                         input logic [7:0] st);
    case (op)
      sfcfe_pkg::OP_STATUS_RD: return st;
      sfcfe_pkg::OP_RELEASE: return sfcfe_pkg::ID_SIG;
      sfcfe_pkg::OP_ID, sfcfe_pkg::OP_ID_SHORT: begin
        case (n)
          9'h001: return sfcfe_pkg::ID_MAKER;
          9'h002: return sfcfe_pkg::ID_TYPE;
          9'h003: return sfcfe_pkg::ID_CAP;
          9'h004: return sfcfe_pkg::ID_LEN;
          default: return sfcfe_pkg::ID_CUST;
        endcase
      end
      default: return sfcfe_pkg::ERASED_BYTE;
    endcase
  endfunction

  // ==========================================================
  // Link domain: frame tracking, reset by deselect
  logic frame_rst;
  sfcfe_ph_e ph_r, ph_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [8:0] byte_r, byte_nxt;
  logic [6:0] shin_r, shin_nxt;
  logic [7:0] byte_in;
  logic byte_done;
  logic [8:0] lsv_s1_r, lsv_s2_r, lsv_s3_r, lsv_r, lsv_nxt;
  logic [8:0] cross_w;
  logic op_ok;

  assign frame_rst = i_rst | link.sel_n;
  assign byte_in = {shin_r, link.serial_data_in};
  assign byte_done = (bit_r == 3'd7);
  assign op_ok = allowed(byte_in, lsv_r[8], lsv_r[sfcfe_pkg::ST_BUSY]);

  always_comb begin
    bit_nxt = bit_r + 3'd1;
    shin_nxt = byte_in[6:0];
    byte_nxt = byte_r;
    ph_nxt = ph_r;
    if (byte_done) begin
      if (byte_r != sfcfe_pkg::N_MAX) begin
        byte_nxt = byte_r + 9'd1;
      end
      if (ph_r == PH_OP) begin
        ph_nxt = op_ok ? PH_RUN : PH_IGN;
      end
    end
  end

  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      ph_r <= PH_OP;
      bit_r <= 3'd0;
      byte_r <= 9'd0;
      shin_r <= 7'd0;
    end else begin
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      shin_r <= shin_nxt;
    end
  end

  // ==========================================================
  // Link domain: command fields that outlive the frame
  logic [7:0] op_r, op_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic armed_r, armed_nxt;
  logic rel_r, rel_nxt;
  logic tog_r, tog_nxt;

  always_comb begin
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    tog_nxt = tog_r;
    rel_nxt = rel_r;
    armed_nxt = 1'b0;
    if (bit_r == 3'd0 && byte_r == 9'd0) begin
      tog_nxt = ~tog_r;
      rel_nxt = 1'b0;
    end
    if (byte_done && ph_r == PH_OP) begin
      op_nxt = byte_in;
      rel_nxt = op_ok && (byte_in == sfcfe_pkg::OP_RELEASE);
      armed_nxt = op_ok && arm_ok(byte_in, sfcfe_pkg::N_OP);
    end else if (byte_done && ph_r == PH_RUN) begin
      if (byte_r < sfcfe_pkg::N_ADDR_END) begin
        addr_nxt = {addr_r[15:0], byte_in};
      end
      if ((op_r == sfcfe_pkg::OP_STATUS_WR && byte_r == sfcfe_pkg::N_OP) ||
          (op_r == sfcfe_pkg::OP_PAGE_PROG && byte_r == sfcfe_pkg::N_ADDR_END)) begin
        wdat_nxt = byte_in;
      end
      armed_nxt = arm_ok(op_r, byte_r + 9'd1);
    end
  end

  always_ff @(posedge link.sclk or posedge i_rst) begin
    if (i_rst) begin
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      wdat_r <= 8'h00;
      armed_r <= 1'b0;
      rel_r <= 1'b0;
      tog_r <= 1'b0;
    end else begin
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      armed_r <= armed_nxt;
      rel_r <= rel_nxt;
      tog_r <= tog_nxt;
    end
  end

  // Core state seen from the link clock; it only runs inside frames
  always_comb begin
    lsv_nxt = (~(lsv_s2_r ^ lsv_s3_r) & lsv_s3_r) | ((lsv_s2_r ^ lsv_s3_r) & lsv_r);
  end

  always_ff @(posedge link.sclk or posedge i_rst) begin
    if (i_rst) begin
      lsv_s1_r <= 9'h000;
      lsv_s2_r <= 9'h000;
      lsv_s3_r <= 9'h000;
      lsv_r <= 9'h000;
    end else begin
      lsv_s1_r <= cross_w;
      lsv_s2_r <= lsv_s1_r;
      lsv_s3_r <= lsv_s2_r;
      lsv_r <= lsv_nxt;
    end
  end

  // ==========================================================
  // Link domain: output on falling edges
  logic sdo_r, sdo_nxt, oe_n_r, oe_n_nxt;
  logic [7:0] tx_w;
  logic [8:0] end_w;

  assign tx_w = tx_byte(op_r, byte_r, lsv_r[7:0]);
  assign end_w = (op_r == sfcfe_pkg::OP_ID) ? sfcfe_pkg::N_ID_END :
                 (op_r == sfcfe_pkg::OP_ID_SHORT) ? sfcfe_pkg::N_ID_SHORT_END : sfcfe_pkg::N_NONE;

  always_comb begin
    sdo_nxt = 1'b1;
    oe_n_nxt = 1'b1;
    if (ph_r == PH_RUN && byte_r >= data_start(op_r) &&
        (end_w == sfcfe_pkg::N_NONE || byte_r < end_w)) begin
      oe_n_nxt = 1'b0;
      sdo_nxt = tx_w[3'd7 - bit_r];
    end
  end

  // Deselect tristates at once, whatever bit was in flight
  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      sdo_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else begin
      sdo_r <= sdo_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign link.sdo_drv = sdo_r;
  assign link.sdo_oe_n = oe_n_r;

  // ==========================================================
  // Core domain: deselect event and execution
  logic sel_s1_r, sel_s2_r, sel_s3_r, selh_r, selh_nxt;
  logic seen_r, seen_nxt;
  sfcfe_cs_e cs_r, cs_nxt;
  logic [11:0] tmr_r, tmr_nxt;
  logic [7:0] nv_r, nv_nxt;
  logic wul_r, wul_nxt, pd_r, pd_nxt;
  logic ex_v_r, ex_v_nxt;
  logic [7:0] ex_op_r, ex_op_nxt, ex_dat_r, ex_dat_nxt;
  logic [23:0] ex_adr_r, ex_adr_nxt;
  logic [7:0] st_w;

  assign st_w = (nv_r & sfcfe_pkg::ST_NV_MASK) |
                {6'h00, wul_r, cs_r == CS_BUSY};
  assign cross_w = {pd_r, st_w};

  always_comb begin
    selh_nxt = (sel_s2_r == sel_s3_r) ? sel_s3_r : selh_r;
    seen_nxt = seen_r;
    cs_nxt = cs_r;
    tmr_nxt = tmr_r;
    nv_nxt = nv_r;
    wul_nxt = wul_r;
    pd_nxt = pd_r;
    ex_v_nxt = 1'b0;
    ex_op_nxt = ex_op_r;
    ex_dat_nxt = ex_dat_r;
    ex_adr_nxt = ex_adr_r;
    if (cs_r == CS_BUSY) begin
      if (tmr_r == 12'd0) begin
        cs_nxt = CS_IDLE;
        wul_nxt = 1'b0;
        if (ex_op_r == sfcfe_pkg::OP_STATUS_WR) begin
          nv_nxt = ex_dat_r & sfcfe_pkg::ST_NV_MASK;
        end
      end else begin
        tmr_nxt = tmr_r - 12'd1;
      end
    end
    // Link fields are frozen while deselected, so reading them here is safe
    if (selh_nxt && !selh_r && tog_r != seen_r) begin
      seen_nxt = tog_r;
      if (rel_r) begin
        pd_nxt = 1'b0;
      end else if (armed_r && cs_r == CS_IDLE && !pd_r) begin
        case (op_r)
          sfcfe_pkg::OP_WR_UNLOCK: wul_nxt = 1'b1;
          sfcfe_pkg::OP_WR_LOCK: wul_nxt = 1'b0;
          sfcfe_pkg::OP_POWER_DOWN: pd_nxt = 1'b1;
          default: begin
            if (wul_r) begin
              cs_nxt = CS_BUSY;
              ex_v_nxt = 1'b1;
              ex_op_nxt = op_r;
              ex_dat_nxt = wdat_r;
              ex_adr_nxt = addr_r & sfcfe_pkg::ADDR_MASK;
              case (op_r)
                sfcfe_pkg::OP_PAGE_PROG: tmr_nxt = 12'(sfcfe_pkg::CYC_PAGE - 1);
                sfcfe_pkg::OP_SECTOR_ERASE: tmr_nxt = 12'(sfcfe_pkg::CYC_SECT - 1);
                sfcfe_pkg::OP_BULK_ERASE: tmr_nxt = 12'(sfcfe_pkg::CYC_BULK - 1);
                default: tmr_nxt = 12'(sfcfe_pkg::CYC_WRSR - 1);
              endcase
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      sel_s3_r <= 1'b1;
      selh_r <= 1'b1;
      seen_r <= 1'b0;
      cs_r <= CS_IDLE;
      tmr_r <= 12'd0;
      nv_r <= sfcfe_pkg::ST_RESET;
      wul_r <= 1'b0;
      pd_r <= 1'b0;
      ex_v_r <= 1'b0;
      ex_op_r <= 8'h00;
      ex_dat_r <= 8'h00;
      ex_adr_r <= 24'h000000;
    end else begin
      sel_s1_r <= link.sel_n;
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
      selh_r <= selh_nxt;
      seen_r <= seen_nxt;
      cs_r <= cs_nxt;
      tmr_r <= tmr_nxt;
      nv_r <= nv_nxt;
      wul_r <= wul_nxt;
      pd_r <= pd_nxt;
      ex_v_r <= ex_v_nxt;
      ex_op_r <= ex_op_nxt;
      ex_dat_r <= ex_dat_nxt;
      ex_adr_r <= ex_adr_nxt;
    end
  end

  assign o_exec_valid = ex_v_r;
  assign o_exec_op = ex_op_r;
  assign o_exec_addr = ex_adr_r;
  assign o_exec_sector = ex_adr_r[sfcfe_pkg::SECTOR_MSB:sfcfe_pkg::SECTOR_LSB];
  assign o_exec_data = ex_dat_r;
  assign o_busy = (cs_r == CS_BUSY);
  assign o_write_unlock_latch = wul_r;
  assign o_power_down = pd_r;
  assign o_status = st_w;
endmodule // sfcfe_device

// ==== sfcfe_host.sv ====
// Host end of the serial flash link
`timescale 1ns/1ns
module sfcfe_host (
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Serial link
  sfcfe_link_if.host link,
  // Command request
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [7:0] i_cmd_op,
  input wire logic [23:0] i_cmd_addr,
  input wire logic [2:0] i_cmd_n_hdr,
  input wire logic [7:0] i_cmd_wdata,
  input wire logic [8:0] i_cmd_n_wr,
  input wire logic [8:0] i_cmd_n_rd,
  // Received bytes and completion
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_done
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_SETUP = 4'b0010, H_SHIFT = 4'b0100, H_GAP = 4'b1000
  } sfcfe_hst_e;

  // ==========================================================
  // Byte sequence: opcode, address and dummy header, write data
  function automatic logic [7:0] hbyte(input logic [9:0] i, input logic [2:0] nh,
                                       input logic [23:0] a, input logic [7:0] wd);
    if (i > {7'd0, nh}) begin
      return wd;
    end
    case (i[2:0])
      3'd1: return a[23:16];
      3'd2: return a[15:8];
      3'd3: return a[7:0];
      default: return 8'h00;
    endcase
  endfunction

  sfcfe_hst_e st_r, st_nxt;
  logic [3:0] div_r, div_nxt;
  logic sclk_r, sclk_nxt, sel_n_r, sel_n_nxt, mosi_r, mosi_nxt;
  logic [2:0] bit_r, bit_nxt, nhdr_r, nhdr_nxt;
  logic [9:0] idx_r, idx_nxt, tot_r, tot_nxt, rxf_r, rxf_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0] wd_r, wd_nxt, txsh_r, txsh_nxt, rxsh_r, rxsh_nxt, rxd_r, rxd_nxt;
  logic rxv_r, rxv_nxt, done_r, done_nxt;
  logic ms1_r, ms2_r, ms3_r, msv_r, msv_nxt;
  logic [7:0] nb_w;

  assign nb_w = hbyte(idx_r + 10'd1, nhdr_r, addr_r, wd_r);

  // ==========================================================
  // Sequencer
  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r + 4'd1;
    sclk_nxt = sclk_r;
    sel_n_nxt = sel_n_r;
    mosi_nxt = mosi_r;
    bit_nxt = bit_r;
    nhdr_nxt = nhdr_r;
    idx_nxt = idx_r;
    tot_nxt = tot_r;
    rxf_nxt = rxf_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    txsh_nxt = txsh_r;
    rxsh_nxt = rxsh_r;
    rxd_nxt = rxd_r;
    rxv_nxt = 1'b0;
    done_nxt = 1'b0;
    msv_nxt = (ms2_r == ms3_r) ? ms3_r : msv_r;
    unique case (st_r)
      H_IDLE: begin
        div_nxt = 4'd0;
        if (i_cmd_valid) begin
          st_nxt = H_SETUP;
          sel_n_nxt = 1'b0;
          nhdr_nxt = i_cmd_n_hdr;
          addr_nxt = i_cmd_addr;
          wd_nxt = i_cmd_wdata;
          idx_nxt = 10'd0;
          bit_nxt = 3'd0;
          rxf_nxt = 10'd1 + {7'd0, i_cmd_n_hdr} + {1'b0, i_cmd_n_wr};
          tot_nxt = rxf_nxt + {1'b0, i_cmd_n_rd};
          txsh_nxt = i_cmd_op;
          mosi_nxt = i_cmd_op[7];
        end
      end
      H_SETUP: begin
        if (div_r == 4'(sfcfe_pkg::SCLK_HALF_CYC - 1)) begin
          div_nxt = 4'd0;
          sclk_nxt = 1'b1;
          st_nxt = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (div_r == 4'(sfcfe_pkg::SCLK_HALF_CYC - 1)) begin
          div_nxt = 4'd0;
          sclk_nxt = ~sclk_r;
          // Sampling at the end of the bit hides the input synchroniser lag
          if (sclk_r) begin
            rxsh_nxt = {rxsh_r[6:0], msv_r};
            bit_nxt = bit_r + 3'd1;
            txsh_nxt = {txsh_r[6:0], 1'b0};
            mosi_nxt = txsh_r[6];
            if (bit_r == 3'd7) begin
              idx_nxt = idx_r + 10'd1;
              if (idx_r >= rxf_r) begin
                rxv_nxt = 1'b1;
                rxd_nxt = {rxsh_r[6:0], msv_r};
              end
              if (idx_r + 10'd1 == tot_r) begin
                st_nxt = H_GAP;
                sel_n_nxt = 1'b1;
                mosi_nxt = 1'b0;
              end else begin
                txsh_nxt = nb_w;
                mosi_nxt = nb_w[7];
              end
            end
          end
        end
      end
      H_GAP: begin
        if (div_r == 4'(sfcfe_pkg::DESEL_CYC)) begin
          st_nxt = H_IDLE;
          done_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= H_IDLE;
      div_r <= 4'd0;
      sclk_r <= 1'b0;
      sel_n_r <= 1'b1;
      mosi_r <= 1'b0;
      bit_r <= 3'd0;
      nhdr_r <= 3'd0;
      idx_r <= 10'd0;
      tot_r <= 10'd0;
      rxf_r <= 10'd0;
      addr_r <= 24'h000000;
      wd_r <= 8'h00;
      txsh_r <= 8'h00;
      rxsh_r <= 8'h00;
      rxd_r <= 8'h00;
      rxv_r <= 1'b0;
      done_r <= 1'b0;
      ms1_r <= 1'b1;
      ms2_r <= 1'b1;
      ms3_r <= 1'b1;
      msv_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      sclk_r <= sclk_nxt;
      sel_n_r <= sel_n_nxt;
      mosi_r <= mosi_nxt;
      bit_r <= bit_nxt;
      nhdr_r <= nhdr_nxt;
      idx_r <= idx_nxt;
      tot_r <= tot_nxt;
      rxf_r <= rxf_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      txsh_r <= txsh_nxt;
      rxsh_r <= rxsh_nxt;
      rxd_r <= rxd_nxt;
      rxv_r <= rxv_nxt;
      done_r <= done_nxt;
      ms1_r <= link.serial_data_out;
      ms2_r <= ms1_r;
      ms3_r <= ms2_r;
      msv_r <= msv_nxt;
    end
  end

  assign link.sclk = sclk_r;
  assign link.sel_n = sel_n_r;
  assign link.serial_data_in = mosi_r;
  assign o_cmd_ready = (st_r == H_IDLE);
  assign o_rx_valid = rxv_r;
  assign o_rx_data = rxd_r;
  assign o_done = done_r;
endmodule // sfcfe_host

// ==== sfcfe_monitor.sv ====
// Protocol checker for the serial flash link
`timescale 1ns/1ns
module sfcfe_monitor (
  // Clock, reset and link wires
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic serial_data_in,
  input wire logic sdo_drv,
  input wire logic sdo_oe_n
);
  // ==========================================================
  // Bit counter, rises of sclk within a frame
  logic sclk_r, sclk_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  always_comb begin
    sclk_nxt = sclk;
    bit_cnt_nxt = sel_n ? 3'h0 : bit_cnt_r + {2'h0, sclk & ~sclk_r};
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_r <= 1'b0;
      bit_cnt_r <= 3'h0;
    end else begin
      sclk_r <= sclk_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_half_high; sclk [*4] ##1 !sclk; endsequence
  sequence s_gap; sel_n [*8] ##1 sel_n ##1 sel_n; endsequence
  sequence s_lead; !sclk [*4] ##1 sclk; endsequence
  a_oe_off_desel: assert property (sel_n |-> sdo_oe_n)
    else $error("data out driven while deselected");
  a_frame_bytes: assert property ($rose(sel_n) |-> bit_cnt_r == 3'h0)
    else $error("deselect off a byte boundary");
  a_desel_gap: assert property ($rose(sel_n) |-> s_gap)
    else $error("deselect gap too short");
  a_half_period: assert property ($rose(sclk) |-> s_half_high)
    else $error("serial clock high phase wrong");
  a_first_rise: assert property ($fell(sel_n) |-> s_lead)
    else $error("first rise not four cycles after select");
  a_sclk_idle: assert property (sel_n |-> !sclk)
    else $error("serial clock runs while deselected");
  a_out_on_fall: assert property ($changed(sdo_drv) && !sel_n && !$past(sel_n) |-> $fell(sclk))
    else $error("data out changed off a falling edge");
  a_in_on_fall: assert property ($changed(serial_data_in) && !$past(sel_n) |-> !sclk)
    else $error("data in changed while clock high");
endmodule // sfcfe_monitor

// ==== serial_flash_command_front_end_tb.sv ====
// Self-checking bench joining host and device ends
`timescale 1ns/1ns
module serial_flash_command_front_end_tb;
  typedef struct {logic [7:0] op; logic [2:0] nh; logic [8:0] nr; logic [7:0] ex;} sfcfe_row_s;
  logic i_core_clk, i_rst, cmd_valid, cmd_ready, rx_valid, done, exec_valid, busy, wul, pd;
  logic [7:0] cmd_op, cmd_wdata, rx_data, exec_op, exec_data, status, ex;
  logic [23:0] cmd_addr, exec_addr;
  logic [2:0] cmd_n_hdr;
  logic [8:0] cmd_n_wr, cmd_n_rd;
  logic [5:0] exec_sector;
  logic [7:0] rx_q[$];
  int miscompares = 0, samples_checked = 0, n_exec = 0, n0;
  sfcfe_row_s rows [9] = '{'{8'h05, 3'h0, 9'h002, 8'h00}, '{8'h06, 3'h0, 9'h000, 8'h00},
    '{8'h05, 3'h0, 9'h002, 8'h02}, '{8'h04, 3'h0, 9'h000, 8'h00}, '{8'h05, 3'h0, 9'h001, 8'h00},
    '{8'h03, 3'h3, 9'h002, 8'hff}, '{8'h0b, 3'h4, 9'h002, 8'hff},
    '{8'hab, 3'h3, 9'h002, sfcfe_pkg::ID_SIG}, '{8'hff, 3'h0, 9'h002, 8'hff}};
  sfcfe_link_if link();
  sfcfe_host i_sfcfe_host (.i_core_clk(i_core_clk), .i_rst(i_rst), .link(link),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr),
    .i_cmd_n_hdr(cmd_n_hdr), .i_cmd_wdata(cmd_wdata), .i_cmd_n_wr(cmd_n_wr),
    .i_cmd_n_rd(cmd_n_rd), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_done(done));
  sfcfe_device i_sfcfe_device (.i_core_clk(i_core_clk), .i_rst(i_rst), .link(link),
    .o_exec_valid(exec_valid), .o_exec_op(exec_op), .o_exec_addr(exec_addr),
    .o_exec_sector(exec_sector), .o_exec_data(exec_data), .o_busy(busy),
    .o_write_unlock_latch(wul), .o_power_down(pd), .o_status(status));
  sfcfe_monitor i_sfcfe_monitor (.i_core_clk(i_core_clk), .i_rst(i_rst), .sclk(link.sclk),
    .sel_n(link.sel_n), .serial_data_in(link.serial_data_in), .sdo_drv(link.sdo_drv),
    .sdo_oe_n(link.sdo_oe_n));
  // ==========================================================
  // Clock, capture and tasks
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    if (exec_valid === 1'b1) n_exec++;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [2:0] nh, input logic [8:0] nw,
                     input logic [8:0] nr);
    rx_q.delete();
    @(posedge i_core_clk) #1;
    {cmd_op, cmd_n_hdr, cmd_n_wr, cmd_n_rd, cmd_valid} = {op, nh, nw, nr, 1'b1};
    @(posedge i_core_clk) #1;
    cmd_valid = 1'b0;
    for (int t = 0; t < 3000 && done !== 1'b1; t++) @(posedge i_core_clk) #1;
    chk(done, 1'b1);
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {i_rst, cmd_valid, cmd_op, cmd_addr, cmd_n_hdr, cmd_wdata, cmd_n_wr, cmd_n_rd} = '0;
    #1 i_rst = 1'b1;
    repeat (8) @(posedge i_core_clk);
    #1 i_rst = 1'b0;
    chk({cmd_ready, wul, status}, 10'h200);
    cmd_addr = 24'h3f1234;
    foreach (rows[r]) begin
      run(rows[r].op, rows[r].nh, 9'h000, rows[r].nr);
      chk(rx_q.size(), rows[r].nr);
      foreach (rx_q[i]) chk(rx_q[i], rows[r].ex);
    end
    for (int k = 0; k < 2; k++) begin
      run(k ? 8'h9e : 8'h9f, 3'h0, 9'h000, k ? 9'h004 : 9'h015);
      chk(rx_q.size(), k ? 4 : 21);
      foreach (rx_q[i]) begin
        ex = i == 0 ? sfcfe_pkg::ID_MAKER : i == 1 ? sfcfe_pkg::ID_TYPE : i == 2 ?
          sfcfe_pkg::ID_CAP : (i == 3 && !k) ? 8'h10 : (i < 20 && !k) ? 8'h00 : 8'hff;
        chk(rx_q[i], ex);
      end
    end
    n0 = n_exec;
    run(8'hd8, 3'h3, 9'h000, 9'h000);
    chk(n_exec, n0);
    run(8'h06, 3'h0, 9'h000, 9'h000);
    run(8'hd8, 3'h3, 9'h000, 9'h000);
    chk({exec_op, exec_addr, exec_sector, busy}, {8'hd8, 24'h3f1234, 6'h3f, 1'b1});
    run(8'h9f, 3'h0, 9'h000, 9'h001);
    chk(rx_q[0], 8'hff);
    run(8'h05, 3'h0, 9'h000, 9'h002);
    chk(rx_q[1][0], 1'b1);
    for (int t = 0; t < 5000 && busy !== 1'b0; t++) @(posedge i_core_clk) #1;
    chk({busy, wul, n_exec}, {2'b00, n0 + 1});
    run(8'h06, 3'h0, 9'h000, 9'h000);
    cmd_wdata = 8'hff;
    run(8'h01, 3'h0, 9'h002, 9'h000);
    chk({n_exec, wul}, {n0 + 1, 1'b1});
    run(8'h01, 3'h0, 9'h001, 9'h000);
    for (int t = 0; t < 5000 && busy !== 1'b0; t++) @(posedge i_core_clk) #1;
    chk({exec_op, exec_data, status}, {8'h01, 8'hff, 8'h9c});
    for (int k = 0; k < 2; k++) begin
      run(8'h06, 3'h0, 9'h000, 9'h000);
      run(k ? 8'hc7 : 8'h02, k ? 3'h0 : 3'h3, k ? 9'h000 : 9'h002, 9'h000);
      chk({exec_op, busy}, {k ? 8'hc7 : 8'h02, 1'b1});
      for (int t = 0; t < 5000 && busy !== 1'b0; t++) @(posedge i_core_clk) #1;
    end
    run(8'hb9, 3'h0, 9'h000, 9'h000);
    run(8'h06, 3'h0, 9'h000, 9'h000);
    chk({pd, wul}, 2'b10);
    run(8'hab, 3'h0, 9'h000, 9'h000);
    chk(pd, 1'b0);
    run(8'h06, 3'h0, 9'h000, 9'h000);
    i_rst = 1'b1;
    repeat (2) @(posedge i_core_clk) #1;
    i_rst = 1'b0;
    chk({cmd_ready, wul, pd, status}, 11'h400);
    give_verdict();
  end
endmodule // serial_flash_command_front_end_tb
